// [core/hrad_consts.svh]
// Address map, field positions, reset values and timing counts of the host register access block.
`ifndef HRAD_CONSTS_SVH
`define HRAD_CONSTS_SVH

`define HRAD_ADDR_W        7
`define HRAD_DATA_W        8
`define HRAD_CHAN_W        3
`define HRAD_GLOBAL_BIT    6
`define HRAD_CHAN_LO       7'h00
`define HRAD_CHAN_HI       7'h19
`define HRAD_GLB_LO        7'h40
`define HRAD_GLB_HI        7'h4A
`define HRAD_IND_LO        7'h78
`define HRAD_IND_HI        7'h7B
`define HRAD_CSR_OFS       7'h44
`define HRAD_ICR1_OFS      7'h48
`define HRAD_ICR3_OFS      7'h4A
`define HRAD_RXD_OFS       7'h78
`define HRAD_RXS_OFS       7'h79
`define HRAD_TXD_OFS       7'h7A
`define HRAD_EOS_OFS       7'h7B
`define HRAD_ICR_CH_LSB    2
`define HRAD_ICR_CH_MSB    4
`define HRAD_CSR_RST       3'h0
`define HRAD_RAM_WORDS     576
`define HRAD_GLB_BASE      10'h200
`define HRAD_DUTY_PERCENT  10
`define HRAD_POLL_SPACING  (100 / `HRAD_DUTY_PERCENT + 1)

`endif

// [core/hrad_pkg.sv]
// Types shared by both ends of the host register access block.
package hrad_pkg;
	typedef enum logic [1:0] {
		HRAD_SVC_NONE = 2'b00,
		HRAD_SVC_RX   = 2'b01,
		HRAD_SVC_TX   = 2'b10,
		HRAD_SVC_MDM  = 2'b11
	} hrad_svc_t;
endpackage : hrad_pkg

// [core/hrad_if.sv]
// Parallel host bus between the host end and the device end.
`timescale 1ns/1ps
`include "hrad_consts.svh"
interface hrad_if;
	logic                      cs;
	logic                      wr;
	logic [`HRAD_ADDR_W-1:0]   addr;
	logic [`HRAD_DATA_W-1:0]   wdata;
	logic [`HRAD_DATA_W-1:0]   rdata;

	modport dev (
		input  cs,
		input  wr,
		input  addr,
		input  wdata,
		output rdata
	);
	modport host (
		output cs,
		output wr,
		output addr,
		output wdata,
		input  rdata
	);
endinterface : hrad_if

// [core/hrad_dev.sv]
// Device end: host register decode, channel select, indexed-indirect mapping and internal bus stealing.
`timescale 1ns/1ps
`include "hrad_consts.svh"
module hrad_dev #(
	parameter int NUM_CHAN = 8
) (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	hrad_if.dev                            bus,
	// Service context and FIFO side of the indexed-indirect registers.
	input  wire hrad_pkg::hrad_svc_t       svc_type,
	input  wire logic [`HRAD_CHAN_W-1:0]   svc_chan,
	input  wire logic [`HRAD_DATA_W-1:0]   rx_fifo_data,
	input  wire logic [`HRAD_DATA_W-1:0]   rx_fifo_stat,
	output logic                           rx_pop,
	output logic                           tx_push,
	output logic [`HRAD_DATA_W-1:0]        tx_data,
	output logic [`HRAD_CHAN_W-1:0]        fifo_chan,
	output logic                           svc_end,
	// Internal processor port; it yields to the host on every clash.
	input  wire logic                      core_req,
	input  wire logic                      core_we,
	input  wire logic [9:0]                core_idx,
	input  wire logic [`HRAD_DATA_W-1:0]   core_wdata,
	output logic [`HRAD_DATA_W-1:0]        core_rdata,
	output logic                           core_gnt,
	output logic [`HRAD_CHAN_W-1:0]        chan_select
);
	// These checks refuse settings that the fixed-width decode below cannot serve.
	if (NUM_CHAN != (1 << `HRAD_CHAN_W)) begin : g_chan_check
		$error("NUM_CHAN must match the channel field width");
	end
	if (`HRAD_GLOBAL_BIT != `HRAD_ADDR_W - 1) begin : g_top_bit_check
		$error("global select must be the top address bit");
	end
	if (`HRAD_GLB_BASE < NUM_CHAN * 64) begin : g_base_check
		$error("global registers overlap the channel file");
	end
	if (`HRAD_GLB_BASE + 64 > `HRAD_RAM_WORDS) begin : g_store_check
		$error("register store too small for the global set");
	end
	if (`HRAD_ICR_CH_MSB - `HRAD_ICR_CH_LSB + 1 != `HRAD_CHAN_W) begin : g_field_check
		$error("channel field of the interrupting-channel read has the wrong width");
	end
	if (`HRAD_DATA_W != `HRAD_CHAN_W + 5) begin : g_data_check
		$error("channel select readback assumes an eight-bit data bus");
	end

	// The register store sits in the state record so that one clocked process owns every bit.
	typedef struct packed {
		logic [`HRAD_RAM_WORDS-1:0][`HRAD_DATA_W-1:0] ram;
		logic [`HRAD_CHAN_W-1:0]                      csr;
		logic [`HRAD_DATA_W-1:0]                      rdata;
		logic                                         rx_pop;
		logic                                         tx_push;
		logic [`HRAD_DATA_W-1:0]                      tx_data;
		logic [`HRAD_CHAN_W-1:0]                      fifo_chan;
		logic                                         svc_end;
		logic [`HRAD_DATA_W-1:0]                      core_rdata;
		logic                                         core_gnt;
	} hrad_dev_state_t;

	hrad_dev_state_t state_reg;
	hrad_dev_state_t state_next;

	// Channel registers live at {channel, A5..A0}; globals sit above them in the same store.
	function automatic logic [9:0] ram_index(input logic [`HRAD_ADDR_W-1:0] a, input logic [`HRAD_CHAN_W-1:0] ch);
		if (a[`HRAD_GLOBAL_BIT]) begin
			ram_index = `HRAD_GLB_BASE + {4'h0, a[5:0]};
		end else begin
			ram_index = {1'b0, ch, a[5:0]};
		end
	endfunction : ram_index

	// The three interrupting-channel locations return the active channel in place of bits 4:2.
	function automatic logic is_icr(input logic [`HRAD_ADDR_W-1:0] a);
		is_icr = (a >= `HRAD_ICR1_OFS) && (a <= `HRAD_ICR3_OFS);
	endfunction : is_icr

	// Core indices beyond the store read as zero and drop writes instead of aliasing.
	function automatic logic in_store(input logic [9:0] idx);
		in_store = (idx < 10'(`HRAD_RAM_WORDS));
	endfunction : in_store

	logic                     in_service;
	logic [`HRAD_CHAN_W-1:0]  chan_eff;
	logic [9:0]               host_idx;
	logic                     rx_ctx;
	logic                     tx_ctx;

	assign in_service = (svc_type != hrad_pkg::HRAD_SVC_NONE);
	// The stored select survives a service request untouched; only the decode switches over.
	assign chan_eff   = in_service ? svc_chan : state_reg.csr;
	assign host_idx   = ram_index(bus.addr, chan_eff);
	assign rx_ctx     = (svc_type == hrad_pkg::HRAD_SVC_RX);
	assign tx_ctx     = (svc_type == hrad_pkg::HRAD_SVC_TX);

	always_comb begin
		// Strobes default low so that each one lasts exactly one cycle.
		state_next          = state_reg;
		state_next.rx_pop   = 1'b0;
		state_next.tx_push  = 1'b0;
		state_next.svc_end  = 1'b0;
		state_next.core_gnt = 1'b0;
		// The host always wins the internal bus; the core waits for as long as chip select is held and retries each cycle,
		// which keeps every host cycle free of wait states.
		if (core_req && !bus.cs) begin
			state_next.core_gnt = 1'b1;
			if (core_we) begin
				if (in_store(core_idx)) begin
					state_next.ram[core_idx] = core_wdata;
				end
			end else begin
				state_next.core_rdata = in_store(core_idx) ? state_reg.ram[core_idx] : 8'h00;
			end
		end
		if (bus.cs) begin
			case (bus.addr)
				`HRAD_CSR_OFS: begin
					// Only the channel number is stored, so the upper bits read back as zero.
					if (bus.wr) begin
						state_next.csr = bus.wdata[`HRAD_CHAN_W-1:0];
					end else begin
						state_next.rdata = {5'h00, state_reg.csr};
					end
				end
				`HRAD_RXD_OFS: begin
					// Only this register pops, so the status of a byte can be read before its data.
					if (!bus.wr && rx_ctx) begin
						state_next.rdata     = rx_fifo_data;
						state_next.rx_pop    = 1'b1;
						state_next.fifo_chan = svc_chan;
					end else begin
						state_next.rdata = 8'h00;
					end
				end
				`HRAD_RXS_OFS: begin
					state_next.rdata = (!bus.wr && rx_ctx) ? rx_fifo_stat : 8'h00;
				end
				`HRAD_TXD_OFS: begin
					// The transmit FIFO cannot be read back; a read returns zero and moves nothing.
					state_next.rdata = 8'h00;
					if (bus.wr && tx_ctx) begin
						state_next.tx_push   = 1'b1;
						state_next.tx_data   = bus.wdata;
						state_next.fifo_chan = svc_chan;
					end
				end
				`HRAD_EOS_OFS: begin
					// Either a read or a write closes service, whichever suits the host driver.
					state_next.rdata   = 8'h00;
					state_next.svc_end = in_service;
				end
				default: begin
					// Off-limit locations are plain store cells; the host is trusted to stay away.
					if (bus.wr) begin
						state_next.ram[host_idx] = bus.wdata;
					end else begin
						state_next.rdata = state_reg.ram[host_idx];
						// The stored byte is left alone; only the returned copy carries the channel.
						if (is_icr(bus.addr)) begin
							state_next.rdata[`HRAD_ICR_CH_MSB:`HRAD_ICR_CH_LSB] = chan_eff;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg     <= '{default: '0};
			state_reg.csr <= `HRAD_CSR_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// Every output is a register bit, so nothing combinational reaches the far end.
	assign bus.rdata   = state_reg.rdata;
	assign rx_pop      = state_reg.rx_pop;
	assign tx_push     = state_reg.tx_push;
	assign tx_data     = state_reg.tx_data;
	assign fifo_chan   = state_reg.fifo_chan;
	assign svc_end     = state_reg.svc_end;
	assign core_rdata  = state_reg.core_rdata;
	assign core_gnt    = state_reg.core_gnt;
	assign chan_select = state_reg.csr;
endmodule : hrad_dev

// [core/hrad_host.sv]
// Host end: issues static bus cycles, refuses accesses the device forbids and paces polling.
`timescale 1ns/1ps
`include "hrad_consts.svh"
module hrad_host (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_b,
	hrad_if.host                           bus,
	input  wire logic                      req,
	input  wire logic                      req_wr,
	input  wire logic [`HRAD_ADDR_W-1:0]   req_addr,
	input  wire logic [`HRAD_DATA_W-1:0]   req_wdata,
	input  wire hrad_pkg::hrad_svc_t       svc_kind,
	input  wire logic                      traffic,
	output logic                           ready,
	output logic                           done,
	output logic                           refused,
	output logic [`HRAD_DATA_W-1:0]        rdata
);
	typedef struct packed {
		logic                      cs;
		logic                      wr;
		logic [`HRAD_ADDR_W-1:0]   addr;
		logic [`HRAD_DATA_W-1:0]   wdata;
		logic                      cap;
		logic                      done;
		logic                      refused;
		logic [`HRAD_DATA_W-1:0]   rdata;
		logic [3:0]                gap;
		logic                      ready;
	} hrad_host_state_t;

	hrad_host_state_t state_reg;
	hrad_host_state_t state_next;

	// Channel-file accesses inside a service routine land on the requesting channel by themselves.
	function automatic logic legal(input logic wr, input logic [`HRAD_ADDR_W-1:0] a, input hrad_pkg::hrad_svc_t k);
		logic ctx;
		ctx   = (k != hrad_pkg::HRAD_SVC_NONE);
		legal = (a <= `HRAD_CHAN_HI) || (a >= `HRAD_GLB_LO && a <= `HRAD_GLB_HI) ||
			(a >= `HRAD_IND_LO && a <= `HRAD_IND_HI);
		if (a >= `HRAD_RXD_OFS && a <= `HRAD_EOS_OFS && !ctx) begin
			legal = 1'b0;
		end
		if (a == `HRAD_TXD_OFS && k != hrad_pkg::HRAD_SVC_TX) begin
			legal = 1'b0;
		end
		if (a == `HRAD_CSR_OFS && wr && ctx) begin
			legal = 1'b0;
		end
	endfunction : legal

	always_comb begin
		state_next         = state_reg;
		state_next.cs      = 1'b0;
		state_next.refused = 1'b0;
		state_next.cap     = state_reg.cs;
		state_next.done    = state_reg.cap;
		if (state_reg.cap) begin
			state_next.rdata = bus.rdata;
		end
		if (state_reg.gap != 4'h0) begin
			state_next.gap = state_reg.gap - 4'h1;
		end
		if (req && state_reg.ready) begin
			if (legal(req_wr, req_addr, svc_kind)) begin
				state_next.cs    = 1'b1;
				state_next.wr    = req_wr;
				state_next.addr  = req_addr;
				state_next.wdata = req_wdata;
				// Under traffic each access holds off the next one so the stolen share stays small;
				// during setup nothing is held back.
				state_next.gap   = traffic ? 4'(`HRAD_POLL_SPACING - 1) : 4'h0;
			end else begin
				state_next.refused = 1'b1;
			end
		end
		state_next.ready = (state_next.gap == 4'h0);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state_reg       <= '{default: '0};
			state_reg.ready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus.cs    = state_reg.cs;
	assign bus.wr    = state_reg.wr;
	assign bus.addr  = state_reg.addr;
	assign bus.wdata = state_reg.wdata;
	assign ready     = state_reg.ready;
	assign done      = state_reg.done;
	assign refused   = state_reg.refused;
	assign rdata     = state_reg.rdata;
endmodule : hrad_host

// [verification/hrad_chk.sv]
// Checker of the host bus between the two ends.
`timescale 1ns/1ps
module hrad_chk (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic       cs,
	input wire logic       wr,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	// The mirror sees host writes only and has no service input, so every channel read is judged against the stored select, in service too.
	logic [7:0] mem_reg [0:575];
	logic [7:0] exp_reg;
	logic [2:0] csel_reg;
	logic [9:0] idx;
	logic       rd;
	assign idx = addr[6] ? {4'h8, addr[5:0]} : {1'b0, csel_reg, addr[5:0]};
	assign rd = cs && !wr;
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			for (int i = 0; i < 576; i++)
				mem_reg[i] <= 8'h00;
			csel_reg <= 3'h0;
		end else begin
			exp_reg <= mem_reg[idx];
			// Only the channel number of the select register is stored.
			if (cs && wr && addr < 7'h78)
				mem_reg[idx] <= (addr == 7'h44) ? {5'h00, wdata[2:0]} : wdata;
			if (cs && wr && addr == 7'h44)
				csel_reg <= wdata[2:0];
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	addr_map_a: assert property (
		cs |-> addr < 7'h1A || (addr > 7'h3F && addr < 7'h4B) || addr > 7'h77) else $error("off-limit address");
	// Any access to the indexed-indirect set also loads the read data, writes included.
	rdata_hold_a: assert property (
		!(cs && (!wr || addr > 7'h77)) |=> $stable(rdata)) else $error("read data moved without a read");
	chan_read_a: assert property (
		rd && addr < 7'h1A |=> rdata == exp_reg) else $error("channel read mismatch");
	glb_read_a: assert property (
		rd && addr > 7'h3F && addr < 7'h48 |=> rdata == exp_reg) else $error("global read mismatch");
	csel_read_a: assert property (
		rd && addr == 7'h44 |=> rdata[2:0] == csel_reg) else $error("channel select read mismatch");
	icr_keep_a: assert property (
		rd && addr > 7'h47 && addr < 7'h4B |=> {rdata[7:5], rdata[1:0]} == {exp_reg[7:5], exp_reg[1:0]})
		else $error("stored bits altered");
	txd_zero_a: assert property (
		rd && addr == 7'h7A |=> rdata == 8'h00) else $error("transmit data read not zero");
	b2b_write_a: assert property (
		cs && wr && addr == 7'h44 ##1 rd && addr == 7'h44 |=> rdata == $past(wdata, 2)) else $error("readback");
	b2b_c: cover property (cs ##1 cs);
	icr_c: cover property (rd && addr == 7'h48);
	txd_c: cover property (cs && wr && addr == 7'h7A);
endmodule : hrad_chk

// [verification/testbench.sv]
// Bench joining the host end and the device end over the host bus.
`timescale 1ns/1ps
module testbench;
	logic                clk_sys = 1'b0, rst_b = 1'b0, req = 1'b0, req_wr = 1'b0, traffic = 1'b0, core_req = 1'b0;
	logic                core_we = 1'b0;
	logic [6:0]          req_addr = 7'h00;
	logic [7:0]          req_wdata = 8'h00, q, core_wdata = 8'h00;
	logic [9:0]          core_idx = 10'h000;
	logic [2:0]          svc_chan = 3'h0, fifo_chan, chan_select;
	hrad_pkg::hrad_svc_t svc = hrad_pkg::HRAD_SVC_NONE;
	logic                ready, done, refused, rx_pop, tx_push, svc_end, core_gnt;
	logic [7:0]          rdata, tx_data, core_rdata;
	int                  n_errors = 0, checks = 0, cyc = 0, t_take = 0, pops = 0, pushes = 0, ends = 0;
	hrad_if link();
	hrad_dev hrad_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus(link.dev), .svc_type(svc), .svc_chan(svc_chan),
		.rx_fifo_data(8'h5A), .rx_fifo_stat(8'h81), .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data),
		.fifo_chan(fifo_chan), .svc_end(svc_end), .core_req(core_req), .core_we(core_we), .core_idx(core_idx),
		.core_wdata(core_wdata), .core_rdata(core_rdata), .core_gnt(core_gnt), .chan_select(chan_select));
	hrad_host hrad_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .bus(link.host), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .svc_kind(svc), .traffic(traffic), .ready(ready),
		.done(done), .refused(refused), .rdata(rdata));
	hrad_chk hrad_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b), .cs(link.cs), .wr(link.wr), .addr(link.addr),
		.wdata(link.wdata), .rdata(link.rdata));
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		pops <= pops + (rx_pop === 1'b1);
		pushes <= pushes + (tx_push === 1'b1);
		ends <= ends + (svc_end === 1'b1);
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// One host request; a hang in either wait counts against the run.
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d, input logic rf);
		int n;
		req <= 1'b1;
		req_wr <= w;
		req_addr <= a;
		req_wdata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ready !== 1'b1 && n < 50);
		t_take = cyc;
		req <= 1'b0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (done !== 1'b1 && refused !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_errors++;
			$display("wrong value at %0t: host request timed out", $time);
			close_out();
		end else begin
			check(refused, rf);
			q = rdata;
		end
	endtask : acc
	// One core port access; the extra edge keeps two accesses from merging into one request.
	task automatic core_acc(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n;
		core_req <= 1'b1;
		core_we <= w;
		core_idx <= i;
		core_wdata <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (core_gnt !== 1'b1 && n < 8);
		core_req <= 1'b0;
		if (n >= 8) begin
			n_errors++;
			$display("wrong value at %0t: core request timed out", $time);
			close_out();
		end else begin
			check(n < 4, 1'b1);
			@(posedge clk_sys);
		end
	endtask : core_acc
	task automatic t_chan();
		acc(1, 7'h44, 8'h05, 0);
		acc(1, 7'h03, 8'hA5, 0);
		acc(1, 7'h44, 8'h02, 0);
		acc(1, 7'h03, 8'h3C, 0);
		acc(0, 7'h03, 8'h00, 0);
		check(q, 8'h3C);
		acc(1, 7'h44, 8'h05, 0);
		acc(0, 7'h03, 8'h00, 0);
		check(q, 8'hA5);
		check(chan_select, 3'h5);
		acc(1, 7'h43, 8'h77, 0);
		acc(0, 7'h43, 8'h00, 0);
		check(q, 8'h77);
		acc(1, 7'h48, 8'hE3, 0);
		acc(0, 7'h48, 8'h00, 0);
		check(q, 8'hF7);
		acc(0, 7'h20, 8'h00, 1);
		acc(0, 7'h78, 8'h00, 1);
		$display("channel test finished");
	endtask : t_chan
	task automatic t_svc();
		svc <= hrad_pkg::HRAD_SVC_RX;
		svc_chan <= 3'h6;
		acc(0, 7'h78, 8'h00, 0);
		check(q, 8'h5A);
		acc(0, 7'h79, 8'h00, 0);
		check(q, 8'h81);
		check(pops, 1);
		check(fifo_chan, 3'h6);
		acc(0, 7'h4A, 8'h00, 0);
		check(q[4:2], 3'h6);
		acc(1, 7'h44, 8'h01, 1);
		acc(0, 7'h7A, 8'h00, 1);
		check(chan_select, 3'h5);
		acc(1, 7'h7B, 8'h00, 0);
		check(ends, 1);
		svc <= hrad_pkg::HRAD_SVC_TX;
		svc_chan <= 3'h1;
		acc(1, 7'h7A, 8'hC3, 0);
		check(pushes, 1);
		check(tx_data, 8'hC3);
		check(fifo_chan, 3'h1);
		acc(0, 7'h7A, 8'h00, 0);
		check(q, 8'h00);
		acc(0, 7'h7B, 8'h00, 0);
		check(ends, 2);
		svc <= hrad_pkg::HRAD_SVC_MDM;
		acc(0, 7'h78, 8'h00, 0);
		check(pops, 1);
		acc(1, 7'h7A, 8'h00, 1);
		svc <= hrad_pkg::HRAD_SVC_NONE;
		$display("service test finished");
	endtask : t_svc
	task automatic t_b2b();
		req <= 1'b1;
		req_wr <= 1'b1;
		req_addr <= 7'h44;
		req_wdata <= 8'h03;
		@(posedge clk_sys);
		req_wr <= 1'b0;
		@(posedge clk_sys);
		req <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check(rdata, 8'h03);
		$display("back-to-back test finished");
	endtask : t_b2b
	task automatic t_pace();
		int n;
		core_acc(1'b0, 10'h203, 8'h00);
		check(core_rdata, 8'h77);
		core_acc(1'b1, 10'h1FF, 8'h6E);
		core_acc(1'b0, 10'h1FF, 8'h00);
		check(core_rdata, 8'h6E);
		traffic <= 1'b1;
		acc(0, 7'h41, 8'h00, 0);
		n = t_take;
		acc(0, 7'h41, 8'h00, 0);
		check(t_take - n, 11);
		traffic <= 1'b0;
		$display("pacing test finished");
	endtask : t_pace
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_chan();
		t_svc();
		t_b2b();
		t_pace();
		close_out();
	end
endmodule : testbench
